// file: logic/tmc_timer.v
// 16-bit timer/counter with prescaler, optional synchroniser and overflow request.
// Assumes an APB master on pclk; pins arrive from outside and are synchronised here.
//
// Operation
// [R1] Count upward through 0000h to FFFFh, wrap, and set overflow flag bit 0.
// [R2] Overflow request reaches the output only while enable bit 0 is set.
// [R3] Control bit 1 picks external rising edges or the instruction clock.
// [R4] Control bit 0 runs the counter; when clear the count holds.
// [R5] Bits 5:4 divide input by 1, 2, 4 or 8.
// [R6] Control bit 3 powers the low-power oscillator; otherwise it is off.
// [R7] Bit 2 bypasses synchronisation for the external source; ignored for internal.
// [R8] Control bits 7 and 6 always read as zero.
// [R9] External edges come from oscillator input when enabled, else counting pin.
// [R10] Oscillator enabled forces both oscillator pins to inputs, ignoring direction bits.
// [R11] Prescaler sits before the synchroniser, which samples its output.
// [R12] Synchronised counter mode in sleep freezes count; prescaler keeps counting.
// [R13] Synchronised mode samples prescaler output on phases two and four.
// [R14] Unsynchronised counter keeps counting in sleep; overflow request wakes the core.
// [R15] Unsynchronised mode is no time base for capture or compare.
// [R16] Byte reads of a running count always return a stable value.
// [R17] Software stops the timer before writing the count in unsynchronised mode.
// [R18] Either capture/compare unit can clear the count through a reset input.
// [R19] Special event trigger, mode code 1011, clears count without setting the flag.
// [R20] A count write coinciding with a trigger wins over the trigger.
// [R21] Writing either count byte clears the prescaler.
// [R22] Power-on reset zeroes control; count bytes are touched by no reset.
// [R23] Software reads high, low, high again and repeats on mismatch.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "tmc_defs.vh"
module tmc_timer #(
  parameter PRESCALE_WIDTH = 3
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ext_count_pin,
  input wire osc_input_pin,
  input wire [1:0] port_c_direction,
  output wire [1:0] port_c_direction_eff,
  output wire osc_amp_enable,
  input wire sleep_mode,
  input wire [3:0] capcomp_mode_code_one,
  input wire capcomp_match_one,
  input wire [3:0] capcomp_mode_code_two,
  input wire capcomp_match_two,
  output wire [15:0] count_value,
  output wire timebase_valid,
  output wire overflow_irq,
  output wire wake_request
);

  reg [7:0] ctrl_r;
  reg flag_r;
  reg irq_en_r;
  reg [7:0] cnt_lo_r;
  reg [7:0] cnt_hi_r;
  reg [1:0] phase_r;
  reg ext_meta_r;
  reg ext_sync_r;
  reg osc_meta_r;
  reg osc_sync_r;
  reg samp_r;
  reg div_d_r;
  reg [31:0] rdata_nxt;
  reg map_hit;

  wire [9:0] reg_idx;
  wire addr_ok;
  wire wr_en;
  wire rd_setup;
  wire wr_ctrl;
  wire wr_flag;
  wire wr_enable;
  wire wr_lo;
  wire wr_hi;
  wire timer_on;
  wire clock_source_select;
  wire sync_bypass;
  wire oscillator_enable;
  wire [1:0] prescale_select;
  wire async_mode;
  wire ext_level;
  wire int_level;
  wire src_level;
  wire div_level;
  wire phase_two;
  wire phase_four;
  wire sample_en;
  wire sync_rise;
  wire async_rise;
  wire count_tick;
  wire inc;
  wire wrap;
  wire special_trigger;
  wire [1:0] unit_match;
  wire [7:0] unit_mode;
  wire [1:0] unit_trigger;

  // Word-aligned index; low address bits must be zero
  assign reg_idx = paddr[11:2];
  assign addr_ok = (paddr[1:0] == 2'b00);
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_ctrl = wr_en & addr_ok & (reg_idx == `TMC_IDX_CTRL);
  assign wr_flag = wr_en & addr_ok & (reg_idx == `TMC_IDX_FLAG);
  assign wr_enable = wr_en & addr_ok & (reg_idx == `TMC_IDX_ENABLE);
  assign wr_lo = wr_en & addr_ok & (reg_idx == `TMC_IDX_CNT_LO);
  assign wr_hi = wr_en & addr_ok & (reg_idx == `TMC_IDX_CNT_HI);

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;

  always @* begin
    case (reg_idx)
      `TMC_IDX_FLAG: map_hit = addr_ok;
      `TMC_IDX_CNT_LO: map_hit = addr_ok;
      `TMC_IDX_CNT_HI: map_hit = addr_ok;
      `TMC_IDX_CTRL: map_hit = addr_ok;
      `TMC_IDX_ENABLE: map_hit = addr_ok;
      default: map_hit = 1'b0;
    endcase
  end

  assign pslverr = psel & penable & ~map_hit;

  assign timer_on = ctrl_r[`TMC_CTRL_ON];
  assign clock_source_select = ctrl_r[`TMC_CTRL_CS];
  assign sync_bypass = ctrl_r[`TMC_CTRL_SYNC];
  assign oscillator_enable = ctrl_r[`TMC_CTRL_OSCEN];
  assign prescale_select = ctrl_r[`TMC_CTRL_PS_HI:`TMC_CTRL_PS_LO];

  // Bypass only matters with the external source selected
  assign async_mode = clock_source_select & sync_bypass; // [R7]

  // Oscillator amplifier is unpowered when disabled to save drain
  assign osc_amp_enable = oscillator_enable; // [R6]

  assign port_c_direction_eff = oscillator_enable ? 2'b11 : port_c_direction; // [R10]

  assign timebase_valid = ~async_mode; // [R15]

  // Control register: only power-on reset clears it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `TMC_CTRL_RESET; // [R22]
      irq_en_r <= `TMC_ENABLE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata[7:0] & `TMC_CTRL_WMASK; // [R8]
      end
      if (wr_enable) begin
        irq_en_r <= pwdata[`TMC_ENABLE_OVF];
      end
    end
  end

  // Pin synchronisers; first stages feed only second stages
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
    end else begin
      ext_meta_r <= ext_count_pin;
      ext_sync_r <= ext_meta_r;
      osc_meta_r <= osc_input_pin;
      osc_sync_r <= osc_meta_r;
    end
  end

  // Four-phase instruction cycle from pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 2'b00;
    end else begin
      phase_r <= phase_r + 2'b01;
    end
  end

  assign phase_two = (phase_r == `TMC_PHASE_TWO);
  assign phase_four = (phase_r == `TMC_PHASE_FOUR);

  assign ext_level = oscillator_enable ? osc_sync_r : ext_sync_r; // [R9]
  // Instruction clock is a quarter of pclk
  assign int_level = phase_r[1];
  assign src_level = clock_source_select ? ext_level : int_level; // [R3]

  // Prescaler after the pin synchronisers, ahead of the sampling synchroniser; keeps running in sleep
  tmc_prescaler #(
    .WIDTH(PRESCALE_WIDTH)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_level(src_level),
    .clear(wr_lo | wr_hi), // [R21]
    .sel(prescale_select), // [R5]
    .div_level(div_level)
  ); // [R11] [R12]

  // Synchronised path samples prescaler output twice per instruction cycle
  assign sample_en = (phase_two | phase_four) & ~sleep_mode; // [R13] [R12]

  // Sample freezes in sleep; a level already high on wake counts once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_r <= 1'b0;
      div_d_r <= 1'b0;
    end else begin
      div_d_r <= div_level;
      if (sample_en) begin
        samp_r <= div_level; // [R13]
      end
    end
  end

  assign sync_rise = sample_en & div_level & ~samp_r;
  // Unsynchronised path follows every prescaler rising edge, sleep or not
  assign async_rise = div_level & ~div_d_r; // [R14]
  assign count_tick = async_mode ? async_rise : sync_rise;
  assign inc = count_tick & timer_on; // [R4]
  assign wrap = inc & (cnt_hi_r == 8'hFF) & (cnt_lo_r == 8'hFF);

  // Only compare units in special-event mode may clear the count
  assign unit_match = {capcomp_match_two, capcomp_match_one};
  assign unit_mode = {capcomp_mode_code_two, capcomp_mode_code_one};

  // One decoder per capture/compare unit; other compare modes never touch the count
  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1) begin : g_unit
      assign unit_trigger[u] = unit_match[u] & (unit_mode[4*u+3:4*u] == `TMC_SPECIAL_TRIGGER); // [R18] [R19]
    end
  endgenerate

  assign special_trigger = |unit_trigger;

  // Count bytes carry no reset; a write, then a trigger, then an increment
  // Count is unknown until software has written both bytes or a trigger clears it
  always @(posedge pclk) begin
    if (wr_lo | wr_hi) begin
      if (wr_lo) begin
        cnt_lo_r <= pwdata[7:0]; // [R20]
      end
      if (wr_hi) begin
        cnt_hi_r <= pwdata[7:0]; // [R20]
      end
    end else if (special_trigger) begin
      cnt_lo_r <= 8'h00; // [R18]
      cnt_hi_r <= 8'h00; // [R18]
    end else if (inc) begin
      cnt_lo_r <= cnt_lo_r + 8'h01; // [R1]
      if (cnt_lo_r == 8'hFF) begin
        cnt_hi_r <= cnt_hi_r + 8'h01; // [R1]
      end
    end
  end

  // Flag set beats a software clear in the same cycle; trigger never sets it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= `TMC_FLAG_RESET;
    end else if (wrap & ~(wr_lo | wr_hi) & ~special_trigger) begin
      flag_r <= 1'b1; // [R1] [R19]
    end else if (wr_flag) begin
      flag_r <= pwdata[`TMC_FLAG_OVF];
    end
  end

  assign overflow_irq = flag_r & irq_en_r; // [R2]
  assign wake_request = overflow_irq; // [R14]
  assign count_value = {cnt_hi_r, cnt_lo_r};

  // Read data captured in the setup cycle from pclk-domain bytes, so it cannot tear
  always @* begin
    rdata_nxt = 32'h00000000;
    if (addr_ok) begin
      case (reg_idx)
        `TMC_IDX_FLAG: rdata_nxt = {31'h00000000, flag_r};
        `TMC_IDX_CNT_LO: rdata_nxt = {24'h000000, cnt_lo_r}; // [R16]
        `TMC_IDX_CNT_HI: rdata_nxt = {24'h000000, cnt_hi_r}; // [R16]
        `TMC_IDX_CTRL: rdata_nxt = {24'h000000, ctrl_r}; // [R8]
        `TMC_IDX_ENABLE: rdata_nxt = {31'h00000000, irq_en_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= rdata_nxt;
    end
  end

endmodule

// file: logic/tmc_defs.vh
// Register map, field positions and reset values of the 16-bit timer/counter.
// Included by tmc_timer and the bench modules; holds definitions only.
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

// Printed register indices; byte address is four times the index
`define TMC_IDX_FLAG 10'h00C
`define TMC_IDX_CNT_LO 10'h00E
`define TMC_IDX_CNT_HI 10'h00F
`define TMC_IDX_CTRL 10'h010
`define TMC_IDX_ENABLE 10'h08C

// Control register fields
`define TMC_CTRL_ON 0
`define TMC_CTRL_CS 1
`define TMC_CTRL_SYNC 2
`define TMC_CTRL_OSCEN 3
`define TMC_CTRL_PS_LO 4
`define TMC_CTRL_PS_HI 5
`define TMC_CTRL_WMASK 8'h3F
`define TMC_CTRL_RESET 8'h00

// Flag and enable register fields
`define TMC_FLAG_OVF 0
`define TMC_ENABLE_OVF 0
`define TMC_FLAG_RESET 1'b0
`define TMC_ENABLE_RESET 1'b0

// Compare mode code that makes a special event trigger
`define TMC_SPECIAL_TRIGGER 4'hB

// Instruction cycle phases, one pclk each
`define TMC_PHASE_TWO 2'h1
`define TMC_PHASE_FOUR 2'h3

`endif

// file: logic/tmc_prescaler.v
// Two-bit selectable divide-by-1/2/4/8 prescaler of the timer/counter.
// Assumes src_level is already in the pclk domain.
`timescale 1ns/100ps
module tmc_prescaler #(
  parameter WIDTH = 3
) (
  input wire pclk,
  input wire presetn,
  input wire src_level,
  input wire clear,
  input wire [1:0] sel,
  output reg div_level
);

  reg src_d_r;
  reg [WIDTH-1:0] cnt_r;
  wire src_rise;

  assign src_rise = src_level & ~src_d_r;

  // Counter stage mimics a ripple chain: bit 0 toggles at each rise of the source, each higher bit when the bit below falls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_d_r <= 1'b0;
      cnt_r <= {WIDTH{1'b0}};
    end else begin
      src_d_r <= src_level;
      if (clear) begin
        cnt_r <= {WIDTH{1'b0}};
      end else if (src_rise) begin
        cnt_r <= cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // Output is the symmetrical tap chosen by the select field
  always @* begin
    case (sel)
      2'b00: div_level = src_level;
      2'b01: div_level = cnt_r[0];
      2'b10: div_level = cnt_r[1];
      2'b11: div_level = cnt_r[2];
      default: div_level = src_level;
    endcase
  end

endmodule

// file: bench/tmc_timer_monitor.sv
// Port checker for the timer/counter.
// Assumes it is bound to tmc_timer and sees its ports only.
`timescale 1ns/100ps
`include "tmc_defs.vh"
module tmc_timer_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [1:0] port_c_direction,
  input wire [1:0] port_c_direction_eff,
  input wire osc_amp_enable,
  input wire [3:0] capcomp_mode_code_one,
  input wire capcomp_match_one,
  input wire [3:0] capcomp_mode_code_two,
  input wire capcomp_match_two,
  input wire [15:0] count_value,
  input wire overflow_irq,
  input wire wake_request
);
  localparam [11:0] A_FL = {`TMC_IDX_FLAG, 2'b00};
  localparam [11:0] A_LO = {`TMC_IDX_CNT_LO, 2'b00};
  localparam [11:0] A_HI = {`TMC_IDX_CNT_HI, 2'b00};
  localparam [11:0] A_CT = {`TMC_IDX_CTRL, 2'b00};
  localparam [11:0] A_EN = {`TMC_IDX_ENABLE, 2'b00};
  wire acc = psel && penable;
  wire wr_lo = acc && pwrite && paddr == A_LO;
  wire wr_any = acc && pwrite && (paddr == A_LO || paddr == A_HI);
  wire trig = (capcomp_match_one && capcomp_mode_code_one == `TMC_SPECIAL_TRIGGER)
    || (capcomp_match_two && capcomp_mode_code_two == `TMC_SPECIAL_TRIGGER);
  // Writes and triggers may move the count any distance
  wire ev = wr_any || trig;
  wire mapped = paddr == A_FL || paddr == A_LO || paddr == A_HI || paddr == A_CT || paddr == A_EN;
  wire [7:0] wbyte = pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_count_step:
    assert property ($changed(count_value) && !$past(ev) |-> count_value == $past(count_value) + 16'h1)
    else $error("count moved by other than one");
  a_trig_clears:
    assert property (trig && !wr_any |=> count_value == 16'h0000) else $error("trigger did not clear");
  a_write_wins:
    assert property (wr_lo |=> count_value[7:0] == $past(wbyte)) else $error("low byte write lost");
  a_err_unmapped:
    assert property (acc |-> pslverr == !mapped) else $error("error response wrong");
  a_err_reads_zero:
    assert property (acc && !pwrite && !mapped |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_ctrl_top_zero:
    assert property (acc && !pwrite && paddr == A_CT |-> prdata[31:6] == 26'h0) else $error("control top bits set");
  a_dir_forced:
    assert property (port_c_direction_eff == (osc_amp_enable ? 2'b11 : port_c_direction))
    else $error("direction not forced");
  a_wake_irq:
    assert property (wake_request == overflow_irq) else $error("wake differs from request");
endmodule
bind tmc_timer tmc_timer_monitor u_mon (.*);

// file: bench/tmc_ext_src.sv
// External clock source: bursts of rising edges on one pin.
// Pins rest low between bursts, as a stopped crystal or source would.
`timescale 1ns/100ps
module tmc_ext_src (
  output reg ext_count_pin,
  output reg osc_input_pin
);
  initial {ext_count_pin, osc_input_pin} = 2'b00;
  task burst(input integer n, input integer osc, input integer half);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        #half;
        if (osc != 0) osc_input_pin = 1'b1;
        else ext_count_pin = 1'b1;
        #half;
        {ext_count_pin, osc_input_pin} = 2'b00;
      end
    end
  endtask
endmodule

// file: bench/test_tmc_timer.sv
// Self-checking bench for the timer/counter over APB.
// Assumes tmc_ext_src drives the pins and the checker is bound.
`timescale 1ns/100ps
`include "tmc_defs.vh"
module test_tmc_timer;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slp = 1'b0, m1 = 1'b0, m2 = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, rd;
  reg [1:0] dir = 2'h2;
  reg [3:0] mc1 = 4'hB, mc2 = 4'hA;
  reg [15:0] v;
  wire [31:0] prdata;
  wire [15:0] cnt;
  wire [1:0] dir_eff;
  wire pready, irq, amp, tbv, ext_pin, osc;
  integer mismatches = 0, total_checks = 0, i;
  localparam [11:0] A_FL = {`TMC_IDX_FLAG, 2'b00};
  localparam [11:0] A_LO = {`TMC_IDX_CNT_LO, 2'b00};
  localparam [11:0] A_HI = {`TMC_IDX_CNT_HI, 2'b00};
  localparam [11:0] A_CT = {`TMC_IDX_CTRL, 2'b00};
  localparam [11:0] A_EN = {`TMC_IDX_ENABLE, 2'b00};
  always #2.5 pclk = ~pclk;
  tmc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .ext_count_pin(ext_pin), .osc_input_pin(osc), .port_c_direction(dir), .port_c_direction_eff(dir_eff),
    .osc_amp_enable(amp), .sleep_mode(slp), .capcomp_mode_code_one(mc1), .capcomp_match_one(m1),
    .capcomp_mode_code_two(mc2), .capcomp_match_two(m2), .count_value(cnt), .timebase_valid(tbv),
    .overflow_irq(irq), .wake_request());
  tmc_ext_src u_src (.ext_count_pin(ext_pin), .osc_input_pin(osc));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task setc(input [15:0] c);
    begin
      apb(1'b1, A_LO, {24'h0, c[7:0]});
      apb(1'b1, A_HI, {24'h0, c[15:8]});
    end
  endtask
  // High, low, high; a changed high byte means the low byte rolled
  task rdcnt;
    reg [7:0] h;
    begin
      v = 16'h0;
      h = 8'h1;
      while (h !== v[15:8]) begin
        apb(1'b0, A_HI, 0);
        h = rd[7:0];
        apb(1'b0, A_LO, 0);
        v = {h, rd[7:0]};
        apb(1'b0, A_HI, 0);
        v[15:8] = rd[7:0];
      end
    end
  endtask
  // Stopped while the count is written, so no write meets an increment
  task ext(input [7:0] c, input integer o, input integer n, input [15:0] e);
    begin
      apb(1'b1, A_CT, {24'h0, c & 8'hFE});
      setc(16'h0000);
      apb(1'b1, A_CT, {24'h0, c});
      u_src.burst(n, o, 23);
      repeat (12) @(posedge pclk);
      apb(1'b1, A_CT, 0);
      rdcnt;
      chk(v, e);
    end
  endtask
  task give_verdict;
    begin
      if (mismatches == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #300000;
    mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CT, 0);
    chk(rd, 0);
    apb(1'b0, A_FL, 0);
    chk(rd, 0);
    apb(1'b1, A_CT, 32'hFF);
    apb(1'b0, A_CT, 0);
    chk(rd, 32'h3F);
    chk(amp, 1);
    chk(dir_eff, 3);
    apb(1'b1, 12'h044, 32'h1);
    apb(1'b0, 12'h044, 0);
    chk(rd, 0);
    for (i = 0; i < 4; i = i + 1) ext({2'b00, i[1:0], 4'h3}, 0, 16, 16'h10 >> i);
    ext(8'h0B, 1, 5, 5);
    ext(8'h0B, 0, 5, 0);
    ext(8'h03, 1, 5, 0);
    ext(8'h07, 0, 6, 6);
    apb(1'b1, A_CT, 32'h06);
    #1 chk(tbv, 0);
    apb(1'b1, A_CT, 32'h02);
    #1 chk(tbv, 1);
    chk(amp, 0);
    chk(dir_eff, 2);
    slp <= 1'b1;
    ext(8'h03, 0, 5, 0);
    ext(8'h07, 0, 5, 5);
    slp <= 1'b0;
    setc(16'h0000);
    apb(1'b1, A_CT, 32'h01);
    repeat (400) @(posedge pclk);
    apb(1'b1, A_CT, 0);
    rdcnt;
    chk(v >= 16'd99 && v <= 16'd103, 1);
    repeat (40) @(posedge pclk);
    chk(cnt, v);
    apb(1'b1, A_EN, 0);
    apb(1'b1, A_FL, 0);
    setc(16'hFFFE);
    apb(1'b1, A_CT, 32'h01);
    repeat (20) @(posedge pclk);
    apb(1'b1, A_CT, 0);
    apb(1'b0, A_FL, 0);
    chk(rd, 1);
    chk(irq, 0);
    apb(1'b1, A_EN, 1);
    #1 chk(irq, 1);
    apb(1'b1, A_FL, 0);
    #1 chk(irq, 0);
    setc(16'hFFFF);
    @(posedge pclk) m1 <= 1'b1;
    @(posedge pclk) m1 <= 1'b0;
    #1 chk(cnt, 0);
    apb(1'b0, A_FL, 0);
    chk(rd, 0);
    setc(16'h1234);
    @(posedge pclk) m2 <= 1'b1;
    @(posedge pclk) m2 <= 1'b0;
    #1 chk(cnt, 16'h1234);
    mc2 <= 4'hB;
    fork
      apb(1'b1, A_LO, 32'h55);
      begin
        repeat (2) @(posedge pclk);
        m2 <= 1'b1;
        @(posedge pclk) m2 <= 1'b0;
      end
    join
    apb(1'b0, A_LO, 0);
    chk(rd, 32'h55);
    give_verdict;
  end
endmodule
